// ---- verilog/adp_regs.vh ----
// register offsets, reset values and field constants for the address/data port block
`ifndef ADP_REGS_VH
`define ADP_REGS_VH
`define ADP_IDX_HIGH_DATA 2'h0
`define ADP_IDX_LOW_DATA 2'h1
`define ADP_IDX_HIGH_DIR 2'h2
`define ADP_IDX_LOW_DIR 2'h3
`define ADP_ADDR_W 4
`define ADP_IDX_LSB 2
`define ADP_IDX_MSB 3
`define ADP_MAPPED_PAGE 2'h0
`define ADP_UNMAPPED_IDX_BIT 3
`define ADP_DIR_RESET 8'h00
`define ADP_PORT_W 8
`define ADP_BUS_W 16
`define ADP_HIGH_LO 8
`define ADP_HIGH_HI 15
`define ADP_LOW_LO 0
`define ADP_LOW_HI 7
`define ADP_READ_ZERO 32'h0000_0000
`define ADP_DATA_W 32
`define ADP_SYNC_STAGES 3
`endif

// ---- verilog/adp_pin_sync.v ----
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
`include "adp_regs.vh"
module adp_pin_sync #(
  parameter WIDTH = 8
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  reg [WIDTH-1:0] level_ff;
  genvar g;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // a bit only changes once the last two stages agree
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_agree
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          level_ff[g] <= 1'b0;
        end else if (ce_in && (s2_ff[g] == s3_ff[g])) begin
          level_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate
  assign level_out = level_ff;
endmodule

// ---- verilog/adp_port_slice.v ----
// one 8-bit port: output latch, direction register, pin drive and read mux
`timescale 1ns/1ps
`include "adp_regs.vh"
module adp_port_slice #(
  parameter WIDTH = 8
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire data_wr_in,
  input wire dir_wr_in,
  input wire [WIDTH-1:0] wdata_in,
  input wire bus_mode_in,
  input wire [WIDTH-1:0] bus_out_in,
  input wire bus_oe_in,
  input wire [WIDTH-1:0] pin_level_in,
  output wire [WIDTH-1:0] data_rd_out,
  output wire [WIDTH-1:0] dir_rd_out,
  output wire [WIDTH-1:0] nxt_pin_o_out,
  output wire [WIDTH-1:0] nxt_pin_oe_out
);
  reg [WIDTH-1:0] latch_ff;
  reg [WIDTH-1:0] dir_ff;
  // output latch has no reset on purpose; contents survive reset
  always @(posedge clk_in) begin
    if (ce_in && data_wr_in) begin
      latch_ff <= wdata_in;
    end
  end
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dir_ff <= `ADP_DIR_RESET;
    end else if (ce_in && dir_wr_in) begin
      dir_ff <= wdata_in;
    end
  end
  assign data_rd_out = (dir_ff & latch_ff) | (~dir_ff & pin_level_in);
  assign dir_rd_out = dir_ff;
  assign nxt_pin_o_out = bus_mode_in ? bus_out_in : latch_ff;
  assign nxt_pin_oe_out = bus_mode_in ? {WIDTH{bus_oe_in}} : dir_ff;
endmodule

// ---- verilog/adp_gpio.v ----
// address/data port pair: gpio registers on avalon-mm, pins shared with external bus
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "adp_regs.vh"
module adp_gpio #(
  parameter WIDTH = `ADP_PORT_W
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire [`ADP_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [`ADP_DATA_W-1:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [`ADP_DATA_W-1:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg [1:0] avs_response_out,
  input wire ext_bus_mode_in,
  input wire [`ADP_BUS_W-1:0] ext_bus_out_in,
  input wire ext_bus_oe_in,
  output reg [`ADP_BUS_W-1:0] ext_bus_in_out,
  input wire [WIDTH-1:0] high_pin_in,
  output reg [WIDTH-1:0] high_pin_o_out,
  output reg [WIDTH-1:0] high_pin_oe_out,
  input wire [WIDTH-1:0] low_pin_in,
  output reg [WIDTH-1:0] low_pin_o_out,
  output reg [WIDTH-1:0] low_pin_oe_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_DECERR = 2'h3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`ADP_DATA_W-1:0] nxt_readdata;
  reg [1:0] nxt_response;
  reg nxt_wait;
  wire [WIDTH-1:0] high_level;
  wire [WIDTH-1:0] low_level;
  wire [WIDTH-1:0] high_rd;
  wire [WIDTH-1:0] low_rd;
  wire [WIDTH-1:0] high_dir;
  wire [WIDTH-1:0] low_dir;
  wire [WIDTH-1:0] high_o;
  wire [WIDTH-1:0] high_oe;
  wire [WIDTH-1:0] low_o;
  wire [WIDTH-1:0] low_oe;
  wire mapped;
  wire wr_go;
  wire [1:0] idx;
  wire req;
  wire take;
  wire idle;
  wire done;
  wire page_ok;
  wire rd_hit;
  wire lane_ok;
  wire sel_high_data;
  wire sel_low_data;
  wire sel_high_dir;
  wire sel_low_dir;
  wire high_data_wr;
  wire low_data_wr;
  wire high_dir_wr;
  wire low_dir_wr;
  wire [WIDTH-1:0] rd_byte;
  wire [`ADP_BUS_W-1:0] pin_levels;
  reg acc_ok_ff;
  reg nxt_acc_ok;

  // decode: true when the address is on the mapped page and its word index equals want
  function hit;
    input [`ADP_ADDR_W-1:0] a;
    input [1:0] want;
    begin
      hit = (a[`ADP_IDX_MSB:`ADP_IDX_LSB] == `ADP_MAPPED_PAGE) && (a[`ADP_IDX_LSB-1:0] == want);
    end
  endfunction

  // readback source per word index; data words already carry the pin/latch mix
  function [WIDTH-1:0] pick_byte;
    input [1:0] sel;
    input [WIDTH-1:0] hd;
    input [WIDTH-1:0] ld;
    input [WIDTH-1:0] hr;
    input [WIDTH-1:0] lr;
    begin
      case (sel)
        `ADP_IDX_HIGH_DATA: pick_byte = hd;
        `ADP_IDX_LOW_DATA: pick_byte = ld;
        `ADP_IDX_HIGH_DIR: pick_byte = hr;
        default: pick_byte = lr;
      endcase
    end
  endfunction

  // answer code once the access is decoded
  function [1:0] resp_code;
    input ok;
    begin
      resp_code = ok ? RESP_OK : RESP_DECERR;
    end
  endfunction

  assign idx = avs_address_in[`ADP_IDX_LSB-1:0];
  assign req = avs_read_in || avs_write_in;
  assign idle = (state_ff == ST_IDLE);
  assign done = (state_ff == ST_DONE);
  // offsets past the four registers are reserved and never alias onto them
  assign page_ok = (avs_address_in[`ADP_IDX_MSB:`ADP_IDX_LSB] == `ADP_MAPPED_PAGE);
  // registers leave the map entirely while the external bus owns the pins
  assign mapped = page_ok && !ext_bus_mode_in;
  // taken only from idle, so back-to-back requests always see one idle gap
  assign take = ce_in && req && idle;
  assign rd_hit = avs_read_in && mapped;
  // only the low byte lane carries register data
  assign lane_ok = avs_byteenable_in[0];
  // write lands where waitrequest is sampled low; mode rechecked so a late flip never writes
  assign wr_go = ce_in && avs_write_in && done && acc_ok_ff && mapped && lane_ok;
  assign sel_high_data = hit(avs_address_in, `ADP_IDX_HIGH_DATA);
  assign sel_low_data = hit(avs_address_in, `ADP_IDX_LOW_DATA);
  assign sel_high_dir = hit(avs_address_in, `ADP_IDX_HIGH_DIR);
  assign sel_low_dir = hit(avs_address_in, `ADP_IDX_LOW_DIR);
  assign high_data_wr = wr_go && sel_high_data;
  assign low_data_wr = wr_go && sel_low_data;
  assign high_dir_wr = wr_go && sel_high_dir;
  assign low_dir_wr = wr_go && sel_low_dir;
  assign rd_byte = pick_byte(idx, high_rd, low_rd, high_dir, low_dir);
  assign pin_levels = {high_level, low_level};

  adp_pin_sync #(
    .WIDTH(WIDTH)
  ) u_high_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in(high_pin_in),
    .level_out(high_level)
  );

  adp_pin_sync #(
    .WIDTH(WIDTH)
  ) u_low_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in(low_pin_in),
    .level_out(low_level)
  );

  adp_port_slice #(
    .WIDTH(WIDTH)
  ) u_high (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .data_wr_in(high_data_wr),
    .dir_wr_in(high_dir_wr),
    .wdata_in(avs_writedata_in[WIDTH-1:0]),
    .bus_mode_in(ext_bus_mode_in),
    .bus_out_in(ext_bus_out_in[`ADP_HIGH_HI:`ADP_HIGH_LO]),
    .bus_oe_in(ext_bus_oe_in),
    .pin_level_in(high_level),
    .data_rd_out(high_rd),
    .dir_rd_out(high_dir),
    .nxt_pin_o_out(high_o),
    .nxt_pin_oe_out(high_oe)
  );

  adp_port_slice #(
    .WIDTH(WIDTH)
  ) u_low (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .data_wr_in(low_data_wr),
    .dir_wr_in(low_dir_wr),
    .wdata_in(avs_writedata_in[WIDTH-1:0]),
    .bus_mode_in(ext_bus_mode_in),
    .bus_out_in(ext_bus_out_in[`ADP_LOW_HI:`ADP_LOW_LO]),
    .bus_oe_in(ext_bus_oe_in),
    .pin_level_in(low_level),
    .data_rd_out(low_rd),
    .dir_rd_out(low_dir),
    .nxt_pin_o_out(low_o),
    .nxt_pin_oe_out(low_oe)
  );

  // one wait cycle per access so readdata is registered with the answer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // waitrequest low for exactly one cycle per taken request
  always @* begin
    nxt_wait = 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_wait = 1'b0;
        end
      end
      ST_DONE: begin
        nxt_wait = 1'b1;
      end
      default: begin
        nxt_wait = 1'b1;
      end
    endcase
  end

  // decode is frozen at the take edge; the write also rechecks mapped and lane_ok, so an OK answer can come without a write
  always @* begin
    nxt_acc_ok = acc_ok_ff;
    if (take) begin
      nxt_acc_ok = mapped;
    end
  end

  always @* begin
    nxt_response = avs_response_out;
    if (take) begin
      nxt_response = resp_code(mapped);
    end
  end

  // readdata and response stand until the next answer; writes answer zero
  always @* begin
    nxt_readdata = avs_readdata_out;
    if (take) begin
      nxt_readdata = `ADP_READ_ZERO;
      if (rd_hit) begin
        nxt_readdata[WIDTH-1:0] = rd_byte;
      end
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= ST_IDLE;
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  // waitrequest idles high so nothing is accepted during reset
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (ce_in) begin
      avs_waitrequest_out <= nxt_wait;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_ok_ff <= 1'b0;
    end else if (ce_in) begin
      acc_ok_ff <= nxt_acc_ok;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_response_out <= RESP_OK;
    end else if (ce_in) begin
      avs_response_out <= nxt_response;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_readdata_out <= `ADP_READ_ZERO;
    end else if (ce_in) begin
      avs_readdata_out <= nxt_readdata;
    end
  end

  // pins registered so every output comes straight from a flip-flop
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      high_pin_o_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      high_pin_o_out <= high_o;
    end
  end

  // pin drive idles off after reset; latch contents stay as they were
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      high_pin_oe_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      high_pin_oe_out <= high_oe;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_pin_o_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      low_pin_o_out <= low_o;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_pin_oe_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      low_pin_oe_out <= low_oe;
    end
  end

  // synchronised levels mirrored for the external bus side
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_bus_in_out <= {`ADP_BUS_W{1'b0}};
    end else if (ce_in) begin
      ext_bus_in_out <= pin_levels;
    end
  end
endmodule

// ---- tb/adp_pad_model.sv ----
// far-side pad model: chip drives where enabled, external device elsewhere
`timescale 1ns/1ps
module adp_pad_model(
  input wire [7:0] o_in,
  input wire [7:0] oe_in,
  input wire [7:0] far_in,
  output wire [7:0] pin_out
);
  // no pull on these pins, so an undriven bit always shows the far device
  assign pin_out = (o_in & oe_in) | (far_in & ~oe_in);
endmodule

// ---- tb/adp_gpio_properties.sv ----
// assertions on the port block's ports
`timescale 1ns/1ps
module adp_gpio_chk(
  input wire clk_in,
  input wire nrst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [3:0] avs_address_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [1:0] avs_response_out,
  input wire ext_bus_mode_in,
  input wire ext_bus_oe_in,
  input wire [15:0] ext_bus_out_in,
  input wire [7:0] high_pin_o_out,
  input wire [7:0] high_pin_oe_out,
  input wire [7:0] low_pin_o_out,
  input wire [7:0] low_pin_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire req = avs_read_in | avs_write_in;
  wire ans = req & !avs_waitrequest_out;
  wire miss = ext_bus_mode_in | (avs_address_in[3:2] != 2'h0);
  rst_oe_a: assert property ($rose(nrst_in) |-> (high_pin_oe_out | low_pin_oe_out) == 8'h00)
    else $error("pins driven after reset");
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low twice");
  answer_a: assert property (req & avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out)
    else $error("no answer");
  miss_a: assert property (ans & miss |-> avs_response_out == 2'h3 && avs_readdata_out == 32'h0)
    else $error("unmapped access answered");
  hit_a: assert property (ans & !miss |-> avs_response_out == 2'h0 && avs_readdata_out[31:8] == 24'h0)
    else $error("mapped access refused");
  bus_o_a: assert property (ext_bus_mode_in |=> {high_pin_o_out, low_pin_o_out} == $past(ext_bus_out_in))
    else $error("pins not on bus");
  bus_oe_a: assert property (ext_bus_mode_in & ext_bus_oe_in |=> {high_pin_oe_out, low_pin_oe_out} == 16'hFFFF)
    else $error("bus drive off");
  bus_off_a: assert property (ext_bus_mode_in & !ext_bus_oe_in |=> {high_pin_oe_out, low_pin_oe_out} == 16'h0)
    else $error("bus drive on");
endmodule
bind adp_gpio adp_gpio_chk i_chk(.clk_in, .nrst_in, .avs_read_in, .avs_write_in, .avs_address_in, .avs_readdata_out,
  .avs_waitrequest_out, .avs_response_out, .ext_bus_mode_in, .ext_bus_oe_in, .ext_bus_out_in, .high_pin_o_out,
  .high_pin_oe_out, .low_pin_o_out, .low_pin_oe_out);

// ---- tb/tb.sv ----
// bench for the address/data port block
`timescale 1ns/1ps
module tb;
  reg clk_in = 0, nrst_in = 0, rd = 0, wr = 0, mode = 0, boe = 0, k;
  reg [3:0] adr = 0;
  reg [7:0] wd = 0, far[2], ld[2], dd[2];
  reg [15:0] bo = 0;
  reg [31:0] s = 29429;
  reg [31:0] exq[$];
  wire [31:0] rdat;
  wire wt;
  wire [7:0] ho, hoe, lo, loe, hp, lp;
  wire [15:0] bi;
  integer n_fail = 0, samples_checked = 0, cyc = 0, i;
  initial forever #2.5 clk_in = ~clk_in;
  adp_gpio i_dut(.clk_in, .nrst_in, .ce_in(1'b1), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in({24'h0, wd}), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .avs_response_out(), .ext_bus_mode_in(mode), .ext_bus_out_in(bo), .ext_bus_oe_in(boe), .ext_bus_in_out(bi),
    .high_pin_in(hp), .high_pin_o_out(ho), .high_pin_oe_out(hoe), .low_pin_in(lp), .low_pin_o_out(lo),
    .low_pin_oe_out(loe));
  adp_pad_model i_ph(.o_in(ho), .oe_in(hoe), .far_in(far[0]), .pin_out(hp));
  adp_pad_model i_pl(.o_in(lo), .oe_in(loe), .far_in(far[1]), .pin_out(lp));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task chk(input [23:0] nm, input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // request held until waitrequest is sampled low, then dropped
  task bus(input w, input [3:0] a, input [7:0] d, input [31:0] e);
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    if (!w) exq.push_back(e);
    @(posedge clk_in);
    while (wt !== 1'b0) @(posedge clk_in);
    rd <= 0;
    wr <= 0;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (rd && wt === 1'b0) chk("rd", rdat, exq.pop_front());
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  initial begin
    far[0] = 8'hA5;
    far[1] = 8'h3C;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1;
    bus(0, 4'h2, 0, 0);
    bus(0, 4'h3, 0, 0);
    for (i = 0; i < 8; i = i + 1) begin
      k = i[0];
      s = xs(s);
      {dd[k], ld[k]} = s[15:0];
      far[k] <= s[23:16];
      bus(1, {3'h0, k}, ld[k], 0);
      bus(1, {3'h1, k}, dd[k], 0);
      // pin levels pass a synchroniser before the data read sees them
      repeat (5) @(posedge clk_in);
      chk("oe", k ? loe : hoe, dd[k]);
      chk("o", (k ? lo : ho) & dd[k], ld[k] & dd[k]);
      bus(0, {3'h0, k}, 0, ld[k] & dd[k] | far[k] & ~dd[k]);
      chk("bi", k ? bi[7:0] : bi[15:8], ld[k] & dd[k] | far[k] & ~dd[k]);
      bus(0, {3'h1, k}, 0, dd[k]);
    end
    nrst_in <= 0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1;
    bus(0, 4'h2, 0, 0);
    bus(1, 4'h2, 8'hFF, 0);
    bus(0, 4'h0, 0, ld[0]);
    bus(1, 4'h9, 8'h5A, 0);
    bus(0, 4'h9, 0, 0);
    // reserved offset must not alias onto the direction register
    bus(1, 4'h6, 8'h00, 0);
    bus(0, 4'h6, 0, 0);
    mode <= 1;
    boe <= 1;
    bo <= s[31:16];
    bus(1, 4'h2, 8'h00, 0);
    bus(0, 4'h0, 0, 0);
    chk("bus", {ho, lo}, bo);
    chk("boe", {hoe, loe}, 16'hFFFF);
    boe <= 0;
    @(posedge clk_in);
    mode <= 0;
    bus(0, 4'h2, 0, 8'hFF);
    // let the watcher take the last answer before closing
    @(posedge clk_in);
    chk("q", exq.size(), 0);
    wrap_up;
  end
endmodule
